/* File: hw/irq_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_consts.vh"
module irq_ctrl (
  input wire sys_clk_in,
  input wire rst_b_in,
  // avalon-mm slave, word address
  input wire [7:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  // timer inputs: one-cycle event pulses on this clock, t1_pwm_mode_in a level, t1_count_in a count value
  input wire t1_ovf_in,
  input wire t1_pwm_turn_in,
  input wire t1_pwm_mode_in,
  input wire t1_cmpa_in,
  input wire t1_cmpb_in,
  input wire t2_ovf_in,
  input wire t2_cmp_in,
  input wire t0_ovf_in,
  input wire t0_cmp_in,
  input wire [15:0] t1_count_in,
  // asynchronous pins
  input wire capture_input_pin_in,
  input wire ext_irq_pin_a_in,
  input wire ext_irq_pin_b_in,
  input wire ext_irq_pin_c_in,
  // core vectoring
  input wire vector_ack_in,
  output reg irq_req_out,
  output reg [4:0] irq_vector_out,
  output reg [15:0] t1_capture_value_out,
  output reg ext_mem_enable_out,
  output reg ext_mem_wait_bit_out,
  output reg sleep_active_out,
  output reg [1:0] sleep_mode_out
);
  // register state
  reg [7:0] mcu_ctrl_r; // general control
  reg [7:0] mcu_ext_r; // extended control
  reg [7:0] tmr_flags_r; // timer flags
  reg [7:0] tmr_masks_r; // timer enables
  reg [7:0] ext_flags_r; // external edge flags
  reg [7:0] ext_masks_r; // external enables
  reg global_en_r; // global interrupt enable
  reg bus_done_r; // one wait cycle then release
  // pin synchronisers, first stage read only by second
  reg [3:0] pin_s1_r;
  reg [3:0] pin_s2_r;
  reg [3:0] pin_old_r; // previous synced level for edges
  reg [7:0] tmr_flags_nxt;
  reg [7:0] ext_flags_nxt;
  reg [4:0] vec_nxt;
  reg [7:0] rd_nxt;
  wire acc = avs_read_in | avs_write_in;
  wire wr_go = avs_write_in & bus_done_r;
  wire rd_go = avs_read_in & bus_done_r;
  wire [7:0] wd = avs_writedata_in[7:0];
  wire cap_pin = pin_s2_r[0];
  wire pa = pin_s2_r[1];
  wire pb = pin_s2_r[2];
  wire pc = pin_s2_r[3];
  wire [1:0] sense_a = mcu_ctrl_r[1:0];
  wire [1:0] sense_b = mcu_ctrl_r[3:2];
  wire cmd_wr = wr_go & (avs_address_in == `OFS_CORE_CMD);
  wire ack = vector_ack_in & irq_req_out;
  // software-driven pins still sampled here, pin input taken regardless of direction
  function detect;
    input [1:0] sense;
    input now;
    input old;
    begin
      case (sense)
        `SENSE_LOW: detect = 1'b0; // level handled without flag
        `SENSE_ANY: detect = now ^ old;
        `SENSE_FALL: detect = old & ~now;
        `SENSE_RISE: detect = now & ~old;
        default: detect = 1'b0;
      endcase
    end
  endfunction
  wire ev_a = detect(sense_a, pa, pin_old_r[1]);
  wire ev_b = detect(sense_b, pb, pin_old_r[2]);
  // pin c edge only
  wire ev_c = mcu_ext_r[`B_C_EDGE] ? (pc & ~pin_old_r[3]) : (~pc & pin_old_r[3]);
  // capture on rising edge of the synced pin
  wire ev_cap = cap_pin & ~pin_old_r[0];
  // level requests live only while pin low
  wire lvl_a = (sense_a == `SENSE_LOW) & ~pa;
  wire lvl_b = (sense_b == `SENSE_LOW) & ~pb;
  // pending sources, mask gating
  wire [7:0] tmr_pend = tmr_flags_r & tmr_masks_r;
  wire pa_req = ext_masks_r[`B_EXT_A] & (ext_flags_r[`B_EXT_A] | lvl_a);
  wire pb_req = ext_masks_r[`B_EXT_B] & (ext_flags_r[`B_EXT_B] | lvl_b);
  wire pc_req = ext_masks_r[`B_EXT_C] & ext_flags_r[`B_EXT_C];

  // synchronise asynchronous pins
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      pin_old_r <= 4'h0;
    end else begin
      pin_s1_r <= {ext_irq_pin_c_in, ext_irq_pin_b_in, ext_irq_pin_a_in, capture_input_pin_in};
      pin_s2_r <= pin_s1_r;
      pin_old_r <= pin_s2_r;
    end
  end

  // priority pick, lowest vector first
  always @* begin
    vec_nxt = `VEC_NONE;
    if (global_en_r) begin
      if (pa_req) vec_nxt = `VEC_EXT_A;
      else if (pb_req) vec_nxt = `VEC_EXT_B;
      else if (pc_req) vec_nxt = `VEC_EXT_C;
      else if (tmr_pend[`B_T2_CMP]) vec_nxt = `VEC_T2_CMP;
      else if (tmr_pend[`B_T2_OVF]) vec_nxt = `VEC_T2_OVF;
      else if (tmr_pend[`B_T1_CAP]) vec_nxt = `VEC_T1_CAP;
      else if (tmr_pend[`B_T1_CMPA]) vec_nxt = `VEC_T1_CMPA;
      else if (tmr_pend[`B_T1_CMPB]) vec_nxt = `VEC_T1_CMPB;
      else if (tmr_pend[`B_T1_OVF]) vec_nxt = `VEC_T1_OVF;
      else if (tmr_pend[`B_T0_CMP]) vec_nxt = `VEC_T0_CMP;
      else if (tmr_pend[`B_T0_OVF]) vec_nxt = `VEC_T0_OVF;
    end
  end

  // flag next values: clear by write-one or ack, set wins
  always @* begin
    tmr_flags_nxt = tmr_flags_r;
    ext_flags_nxt = ext_flags_r;
    if (wr_go && avs_address_in == `OFS_TMR_FLAGS)
      tmr_flags_nxt = tmr_flags_nxt & ~wd;
    if (wr_go && avs_address_in == `OFS_EXT_FLAGS)
      ext_flags_nxt = ext_flags_nxt & ~(wd & 8'he0);
    if (ack) begin
      case (irq_vector_out)
        `VEC_EXT_A: ext_flags_nxt[`B_EXT_A] = 1'b0;
        `VEC_EXT_B: ext_flags_nxt[`B_EXT_B] = 1'b0;
        `VEC_EXT_C: ext_flags_nxt[`B_EXT_C] = 1'b0;
        `VEC_T2_CMP: tmr_flags_nxt[`B_T2_CMP] = 1'b0;
        `VEC_T2_OVF: tmr_flags_nxt[`B_T2_OVF] = 1'b0;
        `VEC_T1_CAP: tmr_flags_nxt[`B_T1_CAP] = 1'b0;
        `VEC_T1_CMPA: tmr_flags_nxt[`B_T1_CMPA] = 1'b0;
        `VEC_T1_CMPB: tmr_flags_nxt[`B_T1_CMPB] = 1'b0;
        `VEC_T1_OVF: tmr_flags_nxt[`B_T1_OVF] = 1'b0;
        `VEC_T0_CMP: tmr_flags_nxt[`B_T0_CMP] = 1'b0;
        `VEC_T0_OVF: tmr_flags_nxt[`B_T0_OVF] = 1'b0;
        default: tmr_flags_nxt = tmr_flags_nxt;
      endcase
    end
    // hardware sets last so they win
    if (t1_pwm_mode_in ? t1_pwm_turn_in : t1_ovf_in)
      tmr_flags_nxt[`B_T1_OVF] = 1'b1;
    if (t1_cmpa_in) tmr_flags_nxt[`B_T1_CMPA] = 1'b1;
    if (t1_cmpb_in) tmr_flags_nxt[`B_T1_CMPB] = 1'b1;
    if (t2_ovf_in) tmr_flags_nxt[`B_T2_OVF] = 1'b1;
    if (ev_cap) tmr_flags_nxt[`B_T1_CAP] = 1'b1;
    if (t2_cmp_in) tmr_flags_nxt[`B_T2_CMP] = 1'b1;
    if (t0_ovf_in) tmr_flags_nxt[`B_T0_OVF] = 1'b1;
    if (t0_cmp_in) tmr_flags_nxt[`B_T0_CMP] = 1'b1;
    if (ev_a) ext_flags_nxt[`B_EXT_A] = 1'b1;
    if (ev_b) ext_flags_nxt[`B_EXT_B] = 1'b1;
    if (ev_c) ext_flags_nxt[`B_EXT_C] = 1'b1;
  end

  // read mux, unmapped reads zero
  always @* begin
    case (avs_address_in)
      `OFS_MCU_CTRL: rd_nxt = mcu_ctrl_r;
      `OFS_MCU_EXT: rd_nxt = mcu_ext_r;
      `OFS_TMR_FLAGS: rd_nxt = tmr_flags_r;
      `OFS_TMR_MASKS: rd_nxt = tmr_masks_r;
      `OFS_EXT_FLAGS: rd_nxt = ext_flags_r;
      `OFS_EXT_MASKS: rd_nxt = ext_masks_r;
      `OFS_CPU_STATUS: rd_nxt = {global_en_r, 7'h00};
      default: rd_nxt = 8'h00;
    endcase
  end

  // registers, bus handshake and core side
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mcu_ctrl_r <= `RESET_VAL;
      mcu_ext_r <= `RESET_VAL;
      tmr_flags_r <= `RESET_VAL;
      tmr_masks_r <= `RESET_VAL;
      ext_flags_r <= `RESET_VAL;
      ext_masks_r <= `RESET_VAL;
      global_en_r <= 1'b0;
      bus_done_r <= 1'b0;
      avs_readdata_out <= 32'h0;
      avs_waitrequest_out <= 1'b1;
      irq_req_out <= 1'b0;
      irq_vector_out <= `VEC_NONE;
      t1_capture_value_out <= 16'h0;
      ext_mem_enable_out <= 1'b0;
      ext_mem_wait_bit_out <= 1'b0;
      sleep_active_out <= 1'b0;
      sleep_mode_out <= `SLP_IDLE;
    end else begin
      // one wait cycle per access, release on second
      bus_done_r <= acc & ~bus_done_r;
      avs_waitrequest_out <= ~(acc & ~bus_done_r);
      if (acc && !bus_done_r)
        avs_readdata_out <= {24'h0, rd_nxt};
      tmr_flags_r <= tmr_flags_nxt;
      ext_flags_r <= ext_flags_nxt;
      if (ev_cap)
        t1_capture_value_out <= t1_count_in;
      if (wr_go) begin
        case (avs_address_in)
          `OFS_MCU_CTRL: mcu_ctrl_r <= wd;
          `OFS_MCU_EXT: mcu_ext_r <= wd;
          `OFS_TMR_MASKS: tmr_masks_r <= wd;
          `OFS_EXT_MASKS: ext_masks_r <= wd & 8'he0;
          default: mcu_ctrl_r <= mcu_ctrl_r;
        endcase
      end
      // global enable: acceptance clears, reti sets, status write loads bit 7
      if (ack)
        global_en_r <= 1'b0;
      else if (cmd_wr && wd[`B_CMD_RETI])
        global_en_r <= 1'b1;
      else if (wr_go && avs_address_in == `OFS_CPU_STATUS)
        global_en_r <= wd[`B_GLOBAL];
      // request stays while a source is pending and global enable is set; drop right after ack
      irq_req_out <= (vec_nxt != `VEC_NONE) & ~ack;
      irq_vector_out <= ack ? `VEC_NONE : vec_nxt;
      ext_mem_enable_out <= mcu_ctrl_r[`B_MEM_EN];
      ext_mem_wait_bit_out <= mcu_ctrl_r[`B_MEM_WAIT];
      sleep_mode_out <= {mcu_ctrl_r[`B_SLEEP_HI], mcu_ext_r[`B_SLEEP_LO]};
      // sleep command honoured only with enable; wake on request
      if (cmd_wr && wd[`B_CMD_SLEEP] && mcu_ctrl_r[`B_SLEEP_EN])
        sleep_active_out <= 1'b1;
      else if (irq_req_out)
        sleep_active_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: hw/irq_ctrl_consts.vh */
`ifndef IRQ_CTRL_CONSTS_VH
`define IRQ_CTRL_CONSTS_VH
// register word offsets (byte address = offset * 4)
`define OFS_MCU_CTRL 8'h35
`define OFS_MCU_EXT 8'h36
`define OFS_TMR_FLAGS 8'h38
`define OFS_TMR_MASKS 8'h39
`define OFS_EXT_FLAGS 8'h3a
`define OFS_EXT_MASKS 8'h3b
`define OFS_CPU_STATUS 8'h3f
`define OFS_CORE_CMD 8'h40
`define RESET_VAL 8'h00
// timer flag / mask bit positions
`define B_T1_OVF 7
`define B_T1_CMPA 6
`define B_T1_CMPB 5
`define B_T2_OVF 4
`define B_T1_CAP 3
`define B_T2_CMP 2
`define B_T0_OVF 1
`define B_T0_CMP 0
// external flag / mask bit positions
`define B_EXT_B 7
`define B_EXT_A 6
`define B_EXT_C 5
// control bit positions
`define B_MEM_EN 7
`define B_MEM_WAIT 6
`define B_SLEEP_EN 5
`define B_SLEEP_HI 4
`define B_SLEEP_LO 7
`define B_C_EDGE 0
`define B_GLOBAL 7
// core command bits
`define B_CMD_SLEEP 0
`define B_CMD_RETI 1
`define B_CMD_ACK 2
// sense codes
`define SENSE_LOW 2'b00
`define SENSE_ANY 2'b01
`define SENSE_FALL 2'b10
`define SENSE_RISE 2'b11
// sleep modes
`define SLP_IDLE 2'b00
`define SLP_RSVD 2'b01
`define SLP_PDOWN 2'b10
`define SLP_PSAVE 2'b11
// vector numbers (word address / 2)
`define VEC_NONE 5'h00
`define VEC_EXT_A 5'h01
`define VEC_EXT_B 5'h02
`define VEC_EXT_C 5'h03
`define VEC_T2_CMP 5'h04
`define VEC_T2_OVF 5'h05
`define VEC_T1_CAP 5'h06
`define VEC_T1_CMPA 5'h07
`define VEC_T1_CMPB 5'h08
`define VEC_T1_OVF 5'h09
`define VEC_T0_CMP 5'h0a
`define VEC_T0_OVF 5'h0b
`endif

/* File: sim/cpu_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic req_in,
  input wire logic [4:0] vec_in,
  input wire logic [3:0] dly_in,
  output logic ack_out,
  output logic [4:0] last_vec_out,
  output logic [7:0] n_ack_out
);
  logic [3:0] wait_r; // cycles the request has stood
  // core accepts a standing request after dly_in cycles, one pulse each
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_out <= 1'b0;
      wait_r <= 4'h0;
      last_vec_out <= 5'h00;
      n_ack_out <= 8'h00;
    end else if (ack_out || !req_in) begin
      ack_out <= 1'b0;
      wait_r <= 4'h0;
    end else if (wait_r + 4'h1 >= dly_in) begin
      ack_out <= 1'b1;
      last_vec_out <= vec_in;
      n_ack_out <= n_ack_out + 8'h01;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: sim/irq_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_monitor (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic avs_waitrequest_out,
  input wire logic [15:0] t1_count_in,
  input wire logic vector_ack_in,
  input wire logic irq_req_out,
  input wire logic [4:0] irq_vector_out,
  input wire logic [15:0] t1_capture_value_out,
  input wire logic ext_mem_enable_out,
  input wire logic ext_mem_wait_bit_out,
  input wire logic sleep_active_out,
  input wire logic [1:0] sleep_mode_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // write taken at this edge
  wire wr_ok = avs_write_in && !avs_waitrequest_out;
  wire wr_slp = wr_ok && (avs_address_in == 8'h35 || avs_address_in == 8'h36);
  sequence s_ctrl_wr;
    wr_ok && avs_address_in == 8'h35;
  endsequence
  property p_mem_en;
    s_ctrl_wr |-> ##2 ext_mem_enable_out == $past(avs_writedata_in[7], 2);
  endproperty
  a_mem_en: assert property (p_mem_en) else $error("memory enable wrong");
  property p_mem_wait;
    s_ctrl_wr |-> ##2 ext_mem_wait_bit_out == $past(avs_writedata_in[6], 2);
  endproperty
  a_mem_wait: assert property (p_mem_wait) else $error("wait bit wrong");
  property p_sleep_set;
    $rose(sleep_active_out) |-> $past(wr_ok && avs_address_in == 8'h40 && avs_writedata_in[0]);
  endproperty
  a_sleep_set: assert property (p_sleep_set) else $error("sleep without command");
  property p_wake;
    irq_req_out |=> !sleep_active_out;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on request");
  property p_sleep_mode;
    $changed(sleep_mode_out) |-> $past(wr_slp) || $past(wr_slp, 2);
  endproperty
  a_sleep_mode: assert property (p_sleep_mode) else $error("mode changed alone");
  property p_ack;
    vector_ack_in && irq_req_out |=> !irq_req_out;
  endproperty
  a_ack: assert property (p_ack) else $error("request kept after accept");
  property p_vec;
    irq_req_out |-> irq_vector_out != 5'h00 && irq_vector_out <= 5'h0b;
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_cap;
    $changed(t1_capture_value_out) |-> t1_capture_value_out == $past(t1_count_in);
  endproperty
  a_cap: assert property (p_cap) else $error("capture value wrong");
endmodule
bind irq_ctrl irq_ctrl_monitor u_mon (.sys_clk_in, .rst_b_in, .avs_address_in, .avs_write_in,
  .avs_writedata_in, .avs_waitrequest_out, .t1_count_in, .vector_ack_in, .irq_req_out,
  .irq_vector_out, .t1_capture_value_out, .ext_mem_enable_out, .ext_mem_wait_bit_out,
  .sleep_active_out, .sleep_mode_out);
`default_nettype wire

/* File: sim/timer_ext_irq_flags_and_mcu_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_ext_irq_flags_and_mcu_control_tb;
  logic clk = 0, rst_b = 0, rd = 0, wr = 0, pwm_m = 0, pwm_t = 0, cap = 0;
  logic pa = 1, pb = 0, pc = 0; // external pins
  logic [7:0] adr = 0, ev = 0; // ev bits follow the flag layout
  logic [31:0] wd = 0;
  logic [3:0] dly = 4'h3; // core answer delay
  wire [31:0] rdat;
  wire wreq, ack, req, memen, memw, slp;
  wire [4:0] vec, lastv;
  wire [15:0] capv;
  wire [1:0] slpm;
  wire [7:0] nack;
  int n_fail = 0, tests_run = 0, i;
  always #5 clk = ~clk;
  irq_ctrl dut (.sys_clk_in(clk), .rst_b_in(rst_b), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .t1_ovf_in(ev[7]), .t1_pwm_turn_in(pwm_t),
    .t1_pwm_mode_in(pwm_m), .t1_cmpa_in(ev[6]), .t1_cmpb_in(ev[5]), .t2_ovf_in(ev[4]),
    .t2_cmp_in(ev[2]), .t0_ovf_in(ev[1]), .t0_cmp_in(ev[0]), .t1_count_in(16'h1234),
    .capture_input_pin_in(cap), .ext_irq_pin_a_in(pa), .ext_irq_pin_b_in(pb),
    .ext_irq_pin_c_in(pc), .vector_ack_in(ack), .irq_req_out(req), .irq_vector_out(vec),
    .t1_capture_value_out(capv), .ext_mem_enable_out(memen), .ext_mem_wait_bit_out(memw),
    .sleep_active_out(slp), .sleep_mode_out(slpm));
  cpu_core_model core (.clk_in(clk), .rst_b_in(rst_b), .req_in(req), .vec_in(vec),
    .dly_in(dly), .ack_out(ack), .last_vec_out(lastv), .n_ack_out(nack));
  task automatic test_done;
    $display("n_fail=%0d tests_run=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    // wait for the slave's answer however long it takes; only the watchdog ends a hang
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat[7:0];
    wr <= 0;
    rd <= 0;
  endtask
  task automatic wr8(input logic [7:0] a, d);
    logic [7:0] q;
    bus(1, a, d, q);
  endtask
  task automatic rd8(input logic [7:0] a, e);
    logic [7:0] q;
    bus(0, a, 8'h00, q);
    chk(q, e);
  endtask
  // one-cycle timer events
  task automatic pulse(input logic [7:0] m);
    @(posedge clk) ev <= m;
    @(posedge clk) ev <= 0;
  endtask
  task automatic ack_wait(input int n);
    repeat (20) @(posedge clk) if (nack == n) break;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    rd8(8'h35, 0);
    rd8(8'h10, 0);
    pulse(8'hf7);
    rd8(8'h38, 8'hf7);
    wr8(8'h38, 8'h00);
    rd8(8'h38, 8'hf7);
    wr8(8'h38, 8'hff);
    rd8(8'h38, 8'h00);
    pwm_m <= 1;
    pulse(8'h80);
    rd8(8'h38, 8'h00);
    @(posedge clk) pwm_t <= 1;
    @(posedge clk) pwm_t <= 0;
    rd8(8'h38, 8'h80);
    pwm_m <= 0;
    cap <= 1;
    repeat (6) @(posedge clk);
    chk(capv, 16'h1234);
    rd8(8'h38, 8'h88);
    $display("flags test done");
    pulse(8'hf7);
    wr8(8'h39, 8'hff);
    chk(req, 0);
    for (i = 0; i < 8; i++) begin
      wr8(8'h3f, 8'h80);
      ack_wait(i + 1);
      chk(lastv, 4 + i);
    end
    rd8(8'h38, 8'h00);
    rd8(8'h3f, 8'h00);
    $display("vector test done");
    dly <= 4'h1;
    wr8(8'h3b, 8'he0);
    wr8(8'h35, 8'h0e);
    wr8(8'h36, 8'h01);
    pa <= 0;
    pb <= 1;
    pc <= 1;
    repeat (6) @(posedge clk);
    rd8(8'h3a, 8'he0);
    wr8(8'h3a, 8'he0);
    wr8(8'h35, 8'h04);
    wr8(8'h36, 8'h00);
    pb <= 0;
    pc <= 0;
    repeat (6) @(posedge clk);
    rd8(8'h3a, 8'ha0);
    wr8(8'h3b, 8'h40);
    wr8(8'h3f, 8'h80);
    ack_wait(9);
    chk(lastv, 1);
    pa <= 1;
    repeat (4) @(posedge clk);
    wr8(8'h3f, 8'h80);
    repeat (8) @(posedge clk);
    chk(nack, 9);
    $display("pin test done");
    wr8(8'h35, 8'hc0);
    repeat (2) @(posedge clk);
    chk({memen, memw}, 2'b11);
    wr8(8'h40, 8'h01);
    repeat (2) @(posedge clk);
    chk(slp, 0);
    for (i = 0; i < 4; i++) begin
      wr8(8'h35, {3'b001, i[1], 4'h0});
      wr8(8'h36, {i[0], 7'h00});
      repeat (2) @(posedge clk);
      chk(slpm, i[1:0]);
    end
    chk(memen, 0);
    wr8(8'h40, 8'h01);
    repeat (2) @(posedge clk);
    chk(slp, 1);
    pa <= 0;
    repeat (10) @(posedge clk);
    chk({slp, nack}, 9'h00a);
    $display("control test done");
    test_done();
  end
  // hang guard, far beyond the expected run
  initial begin
    #200000;
    n_fail++;
    $display("[ERR] %0t watchdog", $time);
    test_done();
  end
endmodule
`default_nettype wire
